/* src/ssdp_defines.vh */
// Constants for the synchronous SRAM data port.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
// Behaviour
// - While the data and parity lines are inputs, their values are captured into a data register on every rising clock edge.
// - Read data driven on the lines is the content of the location addressed at the previous rising edge.
// - While the active-low drive enable is low, the data and parity lines are driven as outputs, except in write cycles and the first read clock.
// - While the drive enable is high, all data and parity lines are released so they act as inputs.
// - With the burst-order strap tied low, the two-bit burst counter follows the linear sequence.
// - With the strap high or left open, the interleaved sequence is used, interleaved being the default.
// - In interleaved order the burst address is the start value exclusive-or the burst step.
// - The data lines are floated whenever a write cycle is detected, whatever the drive enable says.
// - The drive enable is ignored in the first clock of a read that follows a deselected state.
// - When burst advance is sampled low at a rising edge, the burst counter steps to the next address.
`ifndef SSDP_DEFINES_VH
`define SSDP_DEFINES_VH
`define SSDP_DATA_W     36
`define SSDP_DQ_W       32
`define SSDP_PAR_W      4
`define SSDP_ADDR_W     8
`define SSDP_DEPTH      256
`define SSDP_FIFO_DEPTH 16
`define SSDP_FIFO_AW    4
`define SSDP_BURST_RST  2'h0
`endif

/* src/ssdp_top.v */
// Synchronous SRAM data port: pin capture, pipelined read, burst counter, write FIFO.
// Assumes pins arrive from outside the clock domain; strobes decoded by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "ssdp_defines.vh"

module ssdp_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_core_clk,
  input  wire             i_sys_rst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg  [AW:0]      wr_ptr_reg;
  reg  [AW:0]      rd_ptr_reg;
  wire             full;
  wire             empty;
  assign full    = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty   = (wr_ptr_reg == rd_ptr_reg);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign o_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  always @(posedge i_core_clk)
  begin
    if (i_valid && !full)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_data;
    end
  end
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (i_valid && !full)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (i_ready && !empty)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // ssdp_fifo

module ssdp_top (
  input  wire                     i_core_clk,
  input  wire                     i_sys_rst,
  input  wire [`SSDP_DQ_W-1:0]    i_data_lines,
  output reg  [`SSDP_DQ_W-1:0]    o_data_lines,
  output wire                     o_data_lines_oe,
  input  wire [`SSDP_PAR_W-1:0]   i_parity_lines,
  output reg  [`SSDP_PAR_W-1:0]   o_parity_lines,
  output wire                     o_parity_lines_oe,
  input  wire                     i_drive_enable_n,
  input  wire                     i_burst_order,
  input  wire                     i_burst_advance_n,
  input  wire                     i_addr_load,
  input  wire [`SSDP_ADDR_W-1:0]  i_addr,
  input  wire                     i_select,
  input  wire                     i_write,
  output wire [`SSDP_ADDR_W-1:0]  o_burst_addr,
  output wire                     o_write_ready,
  output reg  [`SSDP_DATA_W-1:0]  o_capture_data
);
  reg  [`SSDP_DATA_W-1:0] pin_s1_reg;
  reg  [`SSDP_DATA_W-1:0] pin_s2_reg;
  reg  [2:0]              ctl_s1_reg;
  reg  [2:0]              ctl_s2_reg;
  reg  [`SSDP_DATA_W-1:0] mem_reg [0:`SSDP_DEPTH-1];
  reg  [`SSDP_ADDR_W-1:0] base_reg;
  reg  [1:0]              start_reg;
  reg  [1:0]              step_reg;
  reg  [`SSDP_DATA_W-1:0] rd_data_reg;
  reg                     sel_reg;
  reg                     first_rd_reg;
  reg                     wr_cyc_reg;
  wire                    oe_n;
  wire                    order;
  wire                    adv_n;
  wire [1:0]              low_address_bits;
  wire [`SSDP_ADDR_W-1:0] cur_addr;
  wire                    drive;
  wire [`SSDP_DATA_W-1:0] f_data;
  wire                    f_valid;
  wire                    f_in_ready;

  function [1:0] burst_bits;
    input [1:0] start;
    input [1:0] step;
    input       interleaved;
    begin
      if (interleaved)
        burst_bits = start ^ step;
      else
        burst_bits = start + step;
    end
  endfunction

  // Two-stage synchronisers on the data, parity, drive-enable, burst-order and burst-advance inputs
  always @(posedge i_core_clk)
  begin
    pin_s1_reg <= {i_parity_lines, i_data_lines};
    pin_s2_reg <= pin_s1_reg;
    ctl_s1_reg <= {i_drive_enable_n, i_burst_order, i_burst_advance_n};
    ctl_s2_reg <= ctl_s1_reg;
  end
  assign oe_n  = ctl_s2_reg[2];
  assign order = ctl_s2_reg[1];
  assign adv_n = ctl_s2_reg[0];

  assign low_address_bits = burst_bits(start_reg, step_reg, order);
  assign cur_addr         = {base_reg[`SSDP_ADDR_W-1:2], low_address_bits};
  assign o_burst_addr     = cur_addr;

  // Burst counter
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      base_reg  <= {`SSDP_ADDR_W{1'b0}};
      start_reg <= `SSDP_BURST_RST;
      step_reg  <= `SSDP_BURST_RST;
    end
    else if (i_addr_load)
    begin
      base_reg  <= i_addr;
      start_reg <= i_addr[1:0];
      step_reg  <= `SSDP_BURST_RST;
    end
    else if (!adv_n)
    begin
      step_reg <= step_reg + 2'h1;
    end
  end

  // Input capture register and write FIFO
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_capture_data <= {`SSDP_DATA_W{1'b0}};
    else if (drive == 1'b0)
      o_capture_data <= pin_s2_reg;
  end

  ssdp_fifo #(
    .WIDTH (`SSDP_DATA_W),
    .DEPTH (`SSDP_FIFO_DEPTH),
    .AW    (`SSDP_FIFO_AW)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_data     (pin_s2_reg),
    .i_valid    (i_write && i_select),
    .o_ready    (f_in_ready),
    .o_data     (f_data),
    .o_valid    (f_valid),
    .i_ready    (~(i_select && !i_write))
  );
  assign o_write_ready = f_in_ready;

  always @(posedge i_core_clk)
  begin
    if (f_valid && !(i_select && !i_write))
      mem_reg[cur_addr] <= f_data;
  end

  // Pipelined read and output control
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      rd_data_reg  <= {`SSDP_DATA_W{1'b0}};
      sel_reg      <= 1'b0;
      first_rd_reg <= 1'b0;
      wr_cyc_reg   <= 1'b0;
    end
    else
    begin
      rd_data_reg  <= mem_reg[cur_addr];
      sel_reg      <= i_select;
      first_rd_reg <= i_select && !i_write && !sel_reg;
      wr_cyc_reg   <= i_select && i_write;
    end
  end

  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_data_lines   <= {`SSDP_DQ_W{1'b0}};
      o_parity_lines <= {`SSDP_PAR_W{1'b0}};
    end
    else
    begin
      o_data_lines   <= rd_data_reg[`SSDP_DQ_W-1:0];
      o_parity_lines <= rd_data_reg[`SSDP_DATA_W-1:`SSDP_DQ_W];
    end
  end

  assign drive             = !oe_n && !wr_cyc_reg && !first_rd_reg;
  assign o_data_lines_oe   = drive;
  assign o_parity_lines_oe = drive;
endmodule // ssdp_top
`default_nettype wire

/* test/ssdp_chk_sva.sv */
// Checker for the SRAM data port pin direction and burst counter.
// Assumes it is bound to ssdp_top on one clock with sync reset.
`timescale 1ns/1ps
`default_nettype none
module ssdp_chk (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_drive_enable_n,
  input wire logic       i_burst_order,
  input wire logic       i_burst_advance_n,
  input wire logic       i_addr_load,
  input wire logic [7:0] i_addr,
  input wire logic       i_select,
  input wire logic       i_write,
  input wire logic       o_data_lines_oe,
  input wire logic       o_parity_lines_oe,
  input wire logic [7:0] o_burst_addr
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_on;
    (!i_drive_enable_n && i_select && !i_write)[*4];
  endsequence
  sequence s_lin_move;
    (!i_burst_order && !i_addr_load)[*4] ##0 $changed(o_burst_addr);
  endsequence
  sequence s_ilv_move;
    (i_burst_order && !i_addr_load)[*4] ##0 $changed(o_burst_addr);
  endsequence
  chk_oe_pair: assert property (o_data_lines_oe == o_parity_lines_oe)
    else $error("oe of data and parity differ");
  chk_rel_float: assert property (i_drive_enable_n[*4] |-> !o_data_lines_oe)
    else $error("driving while enable high");
  chk_rd_drive: assert property (s_rd_on |-> o_data_lines_oe)
    else $error("not driving during read");
  chk_wr_float: assert property ((i_write && i_select)[*3] |-> !o_data_lines_oe)
    else $error("driving during write");
  chk_desel_mask: assert property
    (!i_select[*3] ##1 (i_select && !i_write) |=> !o_data_lines_oe)
    else $error("driving in first read clock");
  chk_load_addr: assert property
    (i_addr_load |=> o_burst_addr == $past(i_addr))
    else $error("load not taken");
  chk_hold_addr: assert property
    ((i_burst_advance_n && !i_addr_load)[*4] |-> $stable(o_burst_addr))
    else $error("counter moved without advance");
  chk_lin_step: assert property
    (s_lin_move |-> o_burst_addr[1:0] == $past(o_burst_addr[1:0]) + 2'h1)
    else $error("linear step wrong");
  chk_ilv_step: assert property
    (s_ilv_move |-> o_burst_addr[0] != $past(o_burst_addr[0]))
    else $error("interleaved step wrong");
endmodule // ssdp_chk
bind ssdp_top ssdp_chk u_chk (.i_core_clk, .i_sys_rst, .i_drive_enable_n, .i_burst_order,
  .i_burst_advance_n, .i_addr_load, .i_addr, .i_select, .i_write, .o_data_lines_oe,
  .o_parity_lines_oe, .o_burst_addr);
`default_nettype wire

/* test/ssdp_host.sv */
// Far-side controller model: resolves the shared data and parity wires.
// Assumes the bench sets its drive value just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module ssdp_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_drive,
  input  wire logic [35:0] i_word,
  input  wire logic        i_dut_oe,
  input  wire logic [35:0] i_dut_word,
  output var  logic [35:0] o_wire
);
  logic [35:0] last_reg;
  always_ff @(posedge i_core_clk) last_reg <= o_wire;
  // Undriven wire shows a changing pattern
  always_comb
    if (i_dut_oe) o_wire = i_dut_word;
    else if (i_drive) o_wire = i_word;
    else o_wire = ~last_reg;
endmodule // ssdp_host
`default_nettype wire

/* test/testbench.sv */
// Bench for the SRAM data port: burst orders, write capture, pipelined read.
// Assumes the far-side model resolves the shared pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rst = 1'b1, hdrv = 1'b0, oe_n = 1'b1, order = 1'b1;
  logic        adv_n = 1'b1, ld = 1'b0, sel = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [35:0] hword = 36'h0;
  wire  [35:0] bus, cap;
  wire  [31:0] dq;
  wire  [3:0]  dp;
  wire  [7:0]  baddr;
  wire         oe, poe, wrdy;
  int          n_errors = 0, checked = 0;
  ssdp_top u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_data_lines(bus[31:0]),
    .o_data_lines(dq), .o_data_lines_oe(oe), .i_parity_lines(bus[35:32]),
    .o_parity_lines(dp), .o_parity_lines_oe(poe), .i_drive_enable_n(oe_n),
    .i_burst_order(order), .i_burst_advance_n(adv_n), .i_addr_load(ld), .i_addr(addr),
    .i_select(sel), .i_write(wr), .o_burst_addr(baddr), .o_write_ready(wrdy),
    .o_capture_data(cap));
  ssdp_host u_host (.i_core_clk(clk), .i_drive(hdrv), .i_word(hword), .i_dut_oe(oe),
    .i_dut_word({dp, dq}), .o_wire(bus));
  initial
    forever #5 clk = ~clk;
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task cmp(input logic [35:0] g, input logic [35:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task run_reset();
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
  endtask
  task t_burst(input logic ord, input logic [7:0] a);
    logic [1:0] e;
    order <= ord;
    run_reset();
    sel <= 1'b1;
    addr <= a;
    ld <= 1'b1;
    cyc(1);
    ld <= 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      e = ord ? (a[1:0] ^ k[1:0]) : (a[1:0] + k[1:0]);
      cyc(4);
      cmp({28'h0, a[7:2], e}, {28'h0, baddr});
      adv_n <= 1'b0;
      cyc(1);
      adv_n <= 1'b1;
    end
    $display("burst test done");
  endtask
  task t_data(input logic [35:0] w);
    sel <= 1'b0;
    addr <= 8'h25;
    ld <= 1'b1;
    hword <= w;
    hdrv <= 1'b1;
    cyc(1);
    ld <= 1'b0;
    sel <= 1'b1;
    wr <= 1'b1;
    cyc(6);
    oe_n <= 1'b0;
    @(negedge clk);
    cmp(cap, w);
    cyc(4);
    cmp({35'h0, oe}, 36'h0);
    wr <= 1'b0;
    sel <= 1'b0;
    oe_n <= 1'b1;
    hdrv <= 1'b0;
    cyc(17);
    oe_n <= 1'b0;
    cyc(3);
    sel <= 1'b1;
    cyc(1);
    @(negedge clk);
    cmp({35'h0, oe}, 36'h0);
    cyc(6);
    @(negedge clk);
    cmp({dp, dq}, w);
    cmp(bus, w);
    cmp({35'h0, wrdy}, 36'h1);
    cyc(1);
    oe_n <= 1'b1;
    cyc(4);
    @(negedge clk);
    cmp({35'h0, oe}, 36'h0);
    $display("data test done");
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    t_burst(1'b0, 8'h4b);
    t_burst(1'b1, 8'h71);
    t_burst(1'b1, 8'h3e);
    cyc(1);
    t_data(36'h9a5c3e71b);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
